/* smsh_pkg.sv */
/*
  Shared constants and types of the slot-based serial master: timing counts,
  command layout, operation codes and controller states.
  Assumes a single 100 MHz clock for the whole block.
*/
package smsh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int SLOT_TIME_US   = 1000;
  localparam int SLOT_CYCLES    = SLOT_TIME_US * CLK_MHZ;
  localparam int TIMEOUT_US     = 10;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int FAST_RATE_KBPS = 1000;
  localparam int SLOW_RATE_KBPS = 200;
  // Half bit periods in clock cycles, rounded down
  localparam int HALF_FAST      = (CLK_MHZ * 1000) / (2 * FAST_RATE_KBPS);
  localparam int HALF_SLOW      = (CLK_MHZ * 1000) / (2 * SLOW_RATE_KBPS);
  localparam logic [7:0] HALF_FAST_M1 = 8'(HALF_FAST - 1);
  localparam logic [7:0] HALF_SLOW_M1 = 8'(HALF_SLOW - 1);
  localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Character and command layout
  localparam int         CHAR_BITS     = 8;
  localparam logic [4:0] LAST_PHASE    = 5'h0f;
  localparam int         OP_MSB        = 7;
  localparam int         OP_LSB        = 6;
  localparam int         CNT_MSB       = 5;
  localparam logic [5:0] MAX_CHARS     = 6'h3f;
  localparam logic [5:0] BUF_CHARS     = 6'h08;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [7:0] STATUS_CMD    = 8'h00;

  typedef enum logic [1:0] {
    SMSH_OP_STATUS = 2'b00,
    SMSH_OP_RECV   = 2'b01,
    SMSH_OP_SEND   = 2'b10,
    SMSH_OP_BOTH   = 2'b11
  } smsh_op_t;

  // Gray codes along idle, select, command, ready, transfer, end
  typedef enum logic [2:0] {
    SMSH_IDLE = 3'b000,
    SMSH_RDY1 = 3'b001,
    SMSH_CMD  = 3'b011,
    SMSH_RDY2 = 3'b010,
    SMSH_XFER = 3'b110,
    SMSH_END  = 3'b111
  } smsh_state_t;

endpackage

/* smsh_shift_if.sv */
/*
  Byte handshake between the slot controller and the bit engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface smsh_shift_if;
  logic       start;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       done;
  logic       busy;

  modport master (output start, output tx_byte, input rx_byte, input done, input busy);
  modport engine (input start, input tx_byte, output rx_byte, output done, output busy);
endinterface

/* smsh_shifter.sv */
/*
  Bit engine: shifts one 8-bit character out and in, MSB first, clock idle
  high, data changed on the falling edge and sampled on the rising edge.
  Assumes start is raised only while busy is low.
*/
`timescale 1ns/10ps
module smsh_shifter
  import smsh_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire logic           slow_rate_i,
  smsh_shift_if.engine        sh,
  output logic                serial_clock_out_o,
  output logic                serial_data_out_o,
  input  wire logic           serial_data_in_i
);
  import smsh_pkg::*;

  logic [7:0] div_reg;
  logic [4:0] phase_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_reg;
  logic       act_reg;
  logic       sck_reg;
  logic       sdo_reg;
  logic       done_reg;
  wire  logic tick     = act_reg && (div_reg == 8'h00);
  wire  logic [7:0] half_m1 = slow_rate_i ? HALF_SLOW_M1 : HALF_FAST_M1;
  wire  logic [7:0] shifted = {shift_reg[6:0], serial_data_in_i};

  ////////////////////////////////////////////////////////////////////////////
  // Rate divider, one enable pulse per half bit
  // selectable bit rate
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) div_reg <= 8'h00;
    else if (!act_reg || div_reg == 8'h00) div_reg <= half_m1;
    else div_reg <= div_reg - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_reg   <= 1'b0;
      phase_reg <= 5'h00;
      shift_reg <= 8'h00;
      rx_reg    <= 8'h00;
      sck_reg   <= 1'b1;
      sdo_reg   <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (sh.start && !act_reg) begin
        act_reg   <= 1'b1;
        phase_reg <= 5'h00;
        shift_reg <= sh.tx_byte;
        sdo_reg   <= sh.tx_byte[7];
      end else if (tick) begin
        phase_reg <= phase_reg + 5'h01;
        if (!phase_reg[0]) begin
          sck_reg <= 1'b0;
          if (phase_reg != 5'h00) sdo_reg <= shift_reg[7];
        end else begin
          sck_reg   <= 1'b1;
          shift_reg <= shifted;
          if (phase_reg == LAST_PHASE) begin
            act_reg  <= 1'b0;
            done_reg <= 1'b1;
            rx_reg   <= shifted;
          end
        end
      end
    end
  end

  assign sh.busy            = act_reg;
  assign sh.done            = done_reg;
  assign sh.rx_byte         = rx_reg;
  assign serial_clock_out_o = sck_reg;
  assign serial_data_out_o  = sdo_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_msb_first_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sh.start && !act_reg) |=> (serial_data_out_o == $past(sh.tx_byte[7])))
    else $error("first bit out is not the MSB");
  a_eight_bit_char: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(done_reg) |-> (phase_reg == 5'h10))
    else $error("character did not span eight clocks");

endmodule // smsh_shifter

/* smsh_master.sv */
/*
  Slot-based serial master: one exchange per 1 ms slot with one of two
  slaves, ready handshake with timeout, command byte then data phase,
  receive data delivered through a two-entry buffer.
  Assumes slaves keep the ready-line protocol; all inputs synchronous.
*/
// What this block does
// - One communication sequence at most per fixed 1 ms slot.
// - Each slot sends a command first, then its data transfer.
// - Status command asks the slave how many characters it can move.
// - Receive, transmit and both move data in continuous mode.
// - Command and status are single transfers; payloads go back to back.
// - Transmit data is an incrementing pattern from zero, kept across operations.
// - Bit rate 1 Mbps nominal, selectable down to about 200 kbps.
// - At most 8 characters per slot (buffer size), 8 by default.
// - Ready line checked after select and before each later operation.
// - Every ready wait is bounded by 10 us.
// - On timeout the operation is dropped at once.
// - Timing starts at the select falling edge, polling busy.
// - Command byte goes only after busy was seen low in time.
// - After the command, wait again for ready before data or status.
// - Ready check can be bypassed for slaves with busy tied low.
// - Two select outputs, one shared busy input.
// - Command: top two bits operation, low six bits character count.
// - Data count is smaller of status answer and buffer size.
// - Timeout releases select and switches slave for the next slot.
// - Characters are eight bits, MSB first.
`timescale 1ns/10ps
module smsh_master
  import smsh_pkg::*;
#(
  parameter int SLOT_LEN = smsh_pkg::SLOT_CYCLES
)(
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire logic           slow_rate_i,
  input  wire logic           ready_bypass_i,
  input  wire logic           busy_i,
  input  wire logic           serial_data_in_i,
  output logic                serial_clock_out_o,
  output logic                serial_data_out_o,
  output logic                slave_one_select_b_o,
  output logic                slave_two_select_b_o,
  output logic                timeout_o,
  output logic                mismatch_o,
  output logic [7:0]          rx_data_o,
  output logic                rx_valid_o,
  input  wire logic           rx_ready_i
);
  import smsh_pkg::*;

  smsh_shift_if sh ();

  smsh_shifter u_shifter (
    .clk_i              (clk_i),
    .rst_b_i            (rst_b_i),
    .slow_rate_i        (slow_rate_i),
    .sh                 (sh),
    .serial_clock_out_o (serial_clock_out_o),
    .serial_data_out_o  (serial_data_out_o),
    .serial_data_in_i   (serial_data_in_i)
  );

  function automatic logic [5:0] smsh_min(input logic [5:0] a, input logic [5:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic smsh_op_t smsh_next_op(input smsh_op_t op);
    unique case (op)
      SMSH_OP_STATUS: return SMSH_OP_SEND;
      SMSH_OP_SEND:   return SMSH_OP_BOTH;
      SMSH_OP_BOTH:   return SMSH_OP_RECV;
      SMSH_OP_RECV:   return SMSH_OP_STATUS;
    endcase
  endfunction

  smsh_state_t state_reg;
  smsh_op_t    op_reg;
  logic [16:0] slot_reg;
  logic [9:0]  wait_reg;
  logic [5:0]  idx_reg;
  logic [5:0]  count_reg;
  logic [7:0]  pat_reg;
  logic [7:0]  cur_base_reg;
  logic [7:0]  prev_base_reg;
  logic        slave_reg;
  logic        sel_reg;
  logic        abort_reg;
  logic        timeout_reg;
  logic        mismatch_reg;
  logic        start_reg;
  logic [7:0]  txb_reg;
  logic [7:0]  fifo_mem [2];
  logic        wr_ptr_reg;
  logic        rd_ptr_reg;
  logic [1:0]  fill_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  // slot boundary tick
  wire logic       slot_tick  = (slot_reg == 17'h00000);
  wire logic       ready      = ready_bypass_i || !busy_i;
  wire logic       wait_over  = (wait_reg == TIMEOUT_LAST);
  wire logic       sends_data = op_reg[OP_MSB - 6];
  wire logic       gets_data  = op_reg[OP_LSB - 6];
  wire logic       is_status  = (op_reg == SMSH_OP_STATUS);
  wire logic       fifo_full  = (fill_reg == 2'h2);
  wire logic       push       = sh.done && (state_reg == SMSH_XFER) && !is_status && gets_data;
  wire logic       pop        = rx_valid_o && rx_ready_i;
  wire logic [5:0] xfer_len   = is_status ? 6'h01 : count_reg;
  wire logic       last_byte  = (idx_reg == xfer_len - 6'h01);
  wire logic [7:0] expect_rx  = ~(prev_base_reg + {2'b00, idx_reg});
  wire logic       can_start  = !sh.busy && !start_reg && !(gets_data && !is_status && fifo_full);
  wire logic [7:0] cmd_byte   = is_status ? STATUS_CMD : {op_reg, count_reg};
  wire logic [7:0] data_byte  = sends_data ? pat_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Slot timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) slot_reg <= 17'h00000;
    else if (slot_tick) slot_reg <= 17'(SLOT_LEN - 1);
    else slot_reg <= slot_reg - 17'h00001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg     <= SMSH_IDLE;
      op_reg        <= SMSH_OP_STATUS;
      wait_reg      <= 10'h000;
      idx_reg       <= 6'h00;
      count_reg     <= BUF_CHARS;
      pat_reg       <= PATTERN_RESET;
      cur_base_reg  <= PATTERN_RESET;
      prev_base_reg <= PATTERN_RESET;
      slave_reg     <= 1'b0;
      sel_reg       <= 1'b0;
      abort_reg     <= 1'b0;
      timeout_reg   <= 1'b0;
      mismatch_reg  <= 1'b0;
      start_reg     <= 1'b0;
      txb_reg       <= 8'h00;
    end else begin
      start_reg    <= 1'b0;
      timeout_reg  <= 1'b0;
      mismatch_reg <= 1'b0;
      unique case (state_reg)
        SMSH_IDLE: begin
          // at most one sequence per slot
          if (slot_tick) begin
            // select falls and timing starts together
            sel_reg   <= 1'b1;
            wait_reg  <= 10'h000;
            abort_reg <= 1'b0;
            state_reg <= SMSH_RDY1;
          end
        end
        SMSH_RDY1, SMSH_RDY2: begin
          if (ready) begin
            state_reg <= (state_reg == SMSH_RDY1) ? SMSH_CMD : SMSH_XFER;
            idx_reg   <= 6'h00;
            cur_base_reg <= pat_reg;
          end else if (wait_over) begin
            abort_reg   <= 1'b1;
            timeout_reg <= 1'b1;
            state_reg   <= SMSH_END;
          end else begin
            wait_reg <= wait_reg + 10'h001;
          end
        end
        SMSH_CMD: begin
          if (sh.done) begin
            wait_reg  <= 10'h000;
            state_reg <= SMSH_RDY2;
          end else if (can_start && idx_reg == 6'h00) begin
            // command leads the slot
            // Index marks the command as sent, as the shifter is idle again at done
            start_reg <= 1'b1;
            txb_reg   <= cmd_byte;
            idx_reg   <= 6'h01;
          end
        end
        SMSH_XFER: begin
          if (xfer_len == 6'h00) begin
            state_reg <= SMSH_END;
          end else if (sh.done) begin
            // status answer capped at buffer size
            if (is_status) count_reg <= smsh_min(smsh_min(sh.rx_byte[CNT_MSB:0], BUF_CHARS), MAX_CHARS);
            // answers must be complements of the last payload
            if (!is_status && gets_data && sh.rx_byte != expect_rx) mismatch_reg <= 1'b1;
            idx_reg <= idx_reg + 6'h01;
            if (last_byte) state_reg <= SMSH_END;
          end else if (can_start && idx_reg < xfer_len) begin
            // single transfer for status, continuous for payloads
            start_reg <= 1'b1;
            txb_reg   <= is_status ? STATUS_CMD : data_byte;
            if (sends_data && !is_status) pat_reg <= pat_reg + 8'h01;
          end
        end
        SMSH_END: begin
          // select released at end or abort
          sel_reg   <= 1'b0;
          state_reg <= SMSH_IDLE;
          if (!abort_reg && sends_data) prev_base_reg <= cur_base_reg;
          if (abort_reg || op_reg == SMSH_OP_RECV) begin
            slave_reg <= ~slave_reg;
            op_reg    <= SMSH_OP_STATUS;
          end else begin
            op_reg <= smsh_next_op(op_reg);
          end
        end
      endcase
    end
  end

  assign sh.start   = start_reg;
  assign sh.tx_byte = txb_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer: two entries, stalls the next receive byte when full
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fifo_mem[0] <= 8'h00;
      fifo_mem[1] <= 8'h00;
      wr_ptr_reg  <= 1'b0;
      rd_ptr_reg  <= 1'b0;
      fill_reg    <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_reg] <= sh.rx_byte;
        wr_ptr_reg           <= ~wr_ptr_reg;
      end
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // one select per slave, active low
  assign slave_one_select_b_o = !(sel_reg && !slave_reg);
  assign slave_two_select_b_o = !(sel_reg && slave_reg);
  assign timeout_o  = timeout_reg;
  assign mismatch_o = mismatch_reg;
  assign rx_data_o  = fifo_mem[rd_ptr_reg];
  assign rx_valid_o = (fill_reg != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wait_expired;
    (state_reg == SMSH_RDY1 || state_reg == SMSH_RDY2) && !ready && wait_over;
  endsequence
  sequence s_release;
    (state_reg == SMSH_END) ##1 (slave_one_select_b_o && slave_two_select_b_o);
  endsequence

  a_one_select_only: assert property (
    !(!slave_one_select_b_o && !slave_two_select_b_o))
    else $error("both selects asserted");
  a_timeout_releases: assert property (s_wait_expired |=> s_release)
    else $error("timeout did not release select");
  a_timeout_switch: assert property (
    s_wait_expired |=> ##1 (slave_reg != $past(slave_reg, 2)))
    else $error("slave not switched after timeout");
  a_wait_bounded: assert property (
    (state_reg == SMSH_RDY1 || state_reg == SMSH_RDY2) |-> wait_reg <= TIMEOUT_LAST)
    else $error("ready wait exceeds timeout");
  a_cmd_after_ready: assert property (
    (state_reg == SMSH_RDY1 && ready) |=> (state_reg == SMSH_CMD))
    else $error("command not entered after ready");
  a_bypass_ready: assert property (
    (state_reg == SMSH_RDY2 && ready_bypass_i) |=> (state_reg == SMSH_XFER))
    else $error("bypass did not report ready");
  a_count_capped: assert property (count_reg <= BUF_CHARS)
    else $error("data count above buffer size");
  a_cmd_format: assert property (
    (start_reg && state_reg == SMSH_CMD && !is_status) |-> txb_reg == {op_reg, count_reg})
    else $error("command byte malformed");
  a_select_held: assert property (
    (state_reg inside {SMSH_RDY1, SMSH_CMD, SMSH_RDY2, SMSH_XFER}) |-> sel_reg)
    else $error("select dropped mid sequence");
  a_slot_single: assert property (
    (state_reg == SMSH_IDLE && slot_tick) |=> (state_reg == SMSH_RDY1) ##1 !slot_tick)
    else $error("sequence not started on slot tick");
  a_fifo_no_overflow: assert property (!(push && fifo_full && !pop))
    else $error("receive buffer overflow");

endmodule // smsh_master

/* smsh_slave_model.sv */
/*
  Slave model for the slot master: busy handshake, command decode and echo of
  the complement of stored data. Assumes serial clock idle high, sampled rising.
*/
`timescale 1ns/10ps
module smsh_slave_model
  import smsh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sel_b_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic [11:0] dly_i,
  input  wire logic        absent_i,
  input  wire logic        corrupt_i,
  input  wire logic [7:0]  reply_i,
  output logic             busy_o,
  output logic             miso_o,
  output logic             oe_o
);
  logic [11:0] wait_reg;
  logic [2:0]  bit_reg;
  logic [5:0]  idx_reg;
  logic        first_reg, sclk_reg;
  smsh_op_t    op_reg;
  logic [7:0]  in_reg, out_reg;
  logic [7:0]  mem [64];
  wire  [7:0]  in_byte = {in_reg[6:0], mosi_i};
  wire  [7:0]  echo    = ~mem[idx_reg] ^ {7'h00, corrupt_i};
  wire  [7:0]  tx_byte = first_reg ? 8'h5a : (op_reg == SMSH_OP_STATUS) ? reply_i : op_reg[0] ? echo : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // lines float while unselected
  assign oe_o   = !sel_b_i;
  assign busy_o = absent_i || (wait_reg != 12'h000);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg  <= 12'h000;
      bit_reg   <= 3'h0;
      idx_reg   <= 6'h00;
      first_reg <= 1'b1;
      sclk_reg  <= 1'b1;
      op_reg    <= SMSH_OP_STATUS;
      in_reg    <= 8'h00;
      out_reg   <= 8'h00;
      miso_o    <= 1'b1;
    end else begin
      sclk_reg <= sclk_i;
      if (sel_b_i) begin
        wait_reg  <= dly_i;
        bit_reg   <= 3'h0;
        idx_reg   <= 6'h00;
        first_reg <= 1'b1;
      end else begin
        if (wait_reg != 12'h000) begin
          wait_reg <= wait_reg - 12'h001;
        end
        // bits leave on the falling clock, MSB first
        if (sclk_reg && !sclk_i) begin
          miso_o  <= (bit_reg == 3'h0) ? tx_byte[7] : out_reg[7];
          out_reg <= (bit_reg == 3'h0) ? {tx_byte[6:0], 1'b1} : {out_reg[6:0], 1'b1};
        end
        if (!sclk_reg && sclk_i) begin
          in_reg  <= in_byte;
          bit_reg <= bit_reg + 3'h1;
        end
        if (!sclk_reg && sclk_i && bit_reg == 3'h7) begin
          first_reg <= 1'b0;
          idx_reg   <= first_reg ? 6'h00 : idx_reg + 6'h01;
          // busy again while the command is decoded
          if (first_reg) begin
            op_reg   <= smsh_op_t'(in_byte[7:6]);
            wait_reg <= dly_i;
          end
          // keep received data for the complement echo
          if (!first_reg && op_reg[1]) begin
            mem[idx_reg] <= in_byte;
          end
        end
      end
    end
  end
endmodule // smsh_slave_model

/* tb_serial_master_slot_handshake.sv */
/*
  Self-checking bench for the slot master with two slave models on shared wires.
  Assumes smsh_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb_serial_master_slot_handshake;
  import smsh_pkg::*;
  localparam int SLOT = 11000;
  logic        clk, rst_b, slow, byp, rx_ready, cor, ab2, rdy_n, busy_last, sdi_last;
  logic [11:0] dly;
  logic [7:0]  rep, rx_data, mo, mi, pat, lastb, e1, g1;
  logic        sclk, sdo, s1_b, s2_b, tmo, mm, rx_valid, bz1, bz2, so1, so2, oe1, oe2;
  logic        exp_sl, tmo_seen, mm_seen;
  logic [5:0]  cnt;
  logic [31:0] rnd;
  int          n_fail, cmp_count, stall_left, nb, op_idx;
  time         last_t, fall_t, tmo_t, rise_t, prev_fall;
  logic [7:0]  q[$], mq[$], exp_rx[$], got_rx[$];
  smsh_op_t    seq [4] = '{SMSH_OP_STATUS, SMSH_OP_SEND, SMSH_OP_BOTH, SMSH_OP_RECV};
  // Released shared lines show a changing value, no pull resistor
  wire busy_w = oe1 ? bz1 : oe2 ? bz2 : ~busy_last;
  wire sdi_w  = oe1 ? so1 : oe2 ? so2 : ~sdi_last;

  smsh_master #(.SLOT_LEN(SLOT)) u_dut (.clk_i(clk), .rst_b_i(rst_b), .slow_rate_i(slow),
    .ready_bypass_i(byp), .busy_i(busy_w), .serial_data_in_i(sdi_w), .serial_clock_out_o(sclk),
    .serial_data_out_o(sdo), .slave_one_select_b_o(s1_b), .slave_two_select_b_o(s2_b),
    .timeout_o(tmo), .mismatch_o(mm), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready));
  smsh_slave_model u_slave_one (.clk_i(clk), .rst_b_i(rst_b), .sel_b_i(s1_b), .sclk_i(sclk), .mosi_i(sdo),
    .dly_i(dly), .absent_i(1'b0), .corrupt_i(cor), .reply_i(rep), .busy_o(bz1), .miso_o(so1), .oe_o(oe1));
  smsh_slave_model u_slave_two (.clk_i(clk), .rst_b_i(rst_b), .sel_b_i(s2_b), .sclk_i(sclk), .mosi_i(sdo),
    .dly_i(dly), .absent_i(ab2), .corrupt_i(cor), .reply_i(rep), .busy_o(bz2), .miso_o(so2), .oe_o(oe2));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_rx();
    while (exp_rx.size() > 0 && got_rx.size() > 0) begin
      e1 = exp_rx.pop_front();
      g1 = got_rx.pop_front();
      `CHK("rx data", e1, g1)
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Consumer takes a word at the next rising edge when valid and ready
  always @(negedge clk) begin
    rnd = xs(rnd);
    busy_last <= busy_w;
    sdi_last <= sdi_w;
    rdy_n = (stall_left > 0) ? 1'b0 : rnd[0];
    if (stall_left > 0) stall_left--;
    if (rdy_n && rx_valid === 1'b1) got_rx.push_back(rx_data);
    rx_ready <= rdy_n;
    if (tmo === 1'b1) begin
      tmo_seen = 1'b1;
      tmo_t = $time;
    end
    if (mm === 1'b1) mm_seen = 1'b1;
  end

  always @(posedge sclk) if (!(s1_b && s2_b)) begin
    mo = {mo[6:0], sdo};
    mi = {mi[6:0], sdi_w};
    if (nb % 8 != 0) `CHK("bit period", (slow ? 2 * HALF_SLOW : 2 * HALF_FAST) * 10, int'($time - last_t))
    last_t = $time;
    nb++;
    if (nb % 8 == 0) begin
      q.push_back(mo);
      mq.push_back(mi);
    end
  end

  task automatic run_slot(input int id, input logic [11:0] d, input logic a2, input logic c,
                          input logic [7:0] r, input logic bp, input logic sl, input int st);
    int n;
    smsh_op_t op;
    op = seq[op_idx];
    {dly, ab2, cor, rep, byp, slow} = {d, a2, c, r, bp, sl};
    q.delete();
    mq.delete();
    {nb, tmo_seen, mm_seen} = '0;
    for (n = 0; n < SLOT + 100 && s1_b && s2_b; n++) @(negedge clk);
    if (s1_b && s2_b) begin
      n_fail++;
      stop_test();
    end
    fall_t = $time;
    if (id > 0) `CHK("slot spacing", SLOT * 10, int'(fall_t - prev_fall))
    prev_fall = fall_t;
    `CHK("selected slave", exp_sl, s1_b)
    stall_left = st;
    if (st > 0) begin
      repeat (st) @(negedge clk);
      `CHK("bytes while full", 3, q.size())
      `CHK("valid while full", 1'b1, rx_valid)
    end
    for (n = 0; n < SLOT && !(s1_b && s2_b); n++) @(negedge clk);
    if (!(s1_b && s2_b)) begin
      n_fail++;
      stop_test();
    end
    rise_t = $time;
    if (tmo_seen) begin
      `CHK("timeout delay", 1'b1, (tmo_t - fall_t >= 10000) && (tmo_t - fall_t <= 10030))
      `CHK("release after timeout", 10, int'(rise_t - tmo_t))
      `CHK("bytes after timeout", 0, q.size())
      `CHK("timeout cause", 1'b1, a2 && exp_sl)
      exp_sl = !exp_sl;
      op_idx = 0;
    end else begin
      `CHK("command", {op, (op == SMSH_OP_STATUS) ? 6'h00 : cnt}, q[0])
      `CHK("byte count", (op == SMSH_OP_STATUS) ? 2 : cnt + 1, q.size())
      `CHK("mismatch flag", c && op[0], mm_seen)
      if (op == SMSH_OP_STATUS) begin
        `CHK("status byte", 8'h00, q[1])
        // count capped by the buffer size
        cnt = (mq[1][5:0] < BUF_CHARS) ? mq[1][5:0] : BUF_CHARS;
      end
      if (op[0]) for (int i = 0; i < cnt; i++) exp_rx.push_back(~8'(lastb + i) ^ {7'h00, c});
      if (op[1]) begin
        for (int i = 0; i < cnt; i++) `CHK("tx pattern", 8'(pat + i), q[i + 1])
        lastb = pat;
        pat = 8'(pat + cnt);
      end
      if (op == SMSH_OP_RECV) exp_sl = !exp_sl;
      op_idx = (op == SMSH_OP_RECV) ? 0 : op_idx + 1;
    end
    cmp_rx();
    $display("Slot %0d done", id);
  endtask

  initial begin
    {rst_b, slow, byp, rx_ready, cor, ab2, busy_last, sdi_last, exp_sl, tmo_seen, mm_seen} = '0;
    {dly, rep, mo, mi, lastb, nb, op_idx, n_fail, cmp_count, stall_left} = '0;
    {last_t, prev_fall} = '0;
    rnd = 32'ha6c53ece;
    pat = PATTERN_RESET;
    cnt = BUF_CHARS;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    run_slot(0, 12'(rnd[7:0]), 1'b0, 1'b0, {2'b00, rnd[5:0] | 6'h04}, 1'b0, 1'b0, 0);
    run_slot(1, 12'(rnd[7:0]), 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 0);
    // Corrupted echo must raise the flag yet keep the sequence going
    run_slot(2, 12'(rnd[7:0]), 1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 0);
    run_slot(3, 12'h004, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 3500);
    run_slot(4, 12'h010, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 0);
    // Slave far slower than the timeout, bypass on, low rate
    run_slot(5, 12'h5dc, 1'b0, 1'b0, 8'h3f, 1'b1, 1'b1, 0);
    for (int k = 6; k < 9; k++) run_slot(k, 12'(rnd[7:0]), 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 0);
    repeat (100) @(negedge clk);
    cmp_rx();
    `CHK("rx words left", 0, exp_rx.size() + got_rx.size())
    stop_test();
  end
endmodule // tb_serial_master_slot_handshake
